// File: design/fpx_control.sv
// Floating-point control block: usable gate, control/status register, exceptions, rounding.
`timescale 1ns/1ps
module fpx_control
(
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic [31:0]          sysStatus,
   input  wire fpx_pkg::fpx_issue_t  issue,
   input  wire fpx_pkg::fpx_move_t   move,
   output fpx_pkg::fpx_result_t      result,
   output logic                      moveAck,
   output logic [31:0]               moveRdata,
   output logic                      fpEnabled
);
   import fpx_pkg::*;

   fpx_state_t   state_reg;
   fpx_state_t   state_next;

   logic         cuOn;
   logic         execute;
   logic         roundInc;
   logic [63:0]  rounded;
   logic         inexactCond;
   logic         underCond;
   logic         overCond;
   logic         zeroCond;
   logic         invalidCond;
   logic [4:0]   condVec;
   logic [5:0]   causeNew;
   logic         trapNow;
   logic         toInfinity;
   logic         useSpecial;
   fpx_special_t specialKind;
   logic [63:0]  specialValue;
   logic [63:0]  deliverValue;
   logic         regHit;
   logic [31:0]  csrWord;
   logic [1:0]   rndSelMerged;
   logic [4:0]   enMerged;
   logic [5:0]   causeMerged;
   logic [4:0]   flagsMerged;

   // The usable bit lives in the core's status register; only bit 29 matters here.
   assign cuOn      = (sysStatus & CU_MASK) != 32'h0000_0000;
   assign execute   = issue.valid & cuOn;
   assign fpEnabled = cuOn;

   // Register 31 is the only control register decoded; others read as zero.
   assign regHit = move.regNum == CSR_REGNUM;

   // The register image as software sees it; unlisted bits read as zero.
   always_comb
   begin
      csrWord                               = 32'h0000_0000;
      csrWord[RNDSEL_LSB +: 2]              = state_reg.rndSel;
      csrWord[FLAG_LSB +: 5]                = state_reg.flags;
      csrWord[EN_LSB +: 5]                  = state_reg.en;
      csrWord[CAUSE_LSB +: 6]               = state_reg.cause;
      csrWord[NANENC_BIT]                   = NANENC_VALUE;
      csrWord[ABSSEM_BIT]                   = ABSSEM_VALUE;
   end

   // Rounding of the truncated datapath value under the current mode.
   fpx_round_inc u_round
   (
      .rndSel (state_reg.rndSel),
      .sign   (issue.sign),
      .lsb    (issue.raw[0]),
      .guard  (issue.guard),
      .sticky (issue.sticky),
      .inc    (roundInc)
   );

   // The increment carries naturally into the exponent, so a mantissa
   // overflow on rounding becomes the next binade without extra logic.
   always_comb
   begin
      rounded = issue.raw + {63'h0, roundInc};
      if (!issue.dbl)
      begin
         rounded[63:32] = 32'h0000_0000;
      end
   end

   // Condition detection. Invalid masks the other conditions since the
   // operation then has no numeric result to judge.
   always_comb
   begin
      invalidCond = issue.invalid;
      zeroCond    = issue.divZero & ~issue.invalid;
      overCond    = issue.overflow & ~invalidCond & ~zeroCond;
      inexactCond = (issue.guard | issue.sticky | overCond)
                    & ~invalidCond & ~zeroCond;
      // Disabled underflow is only noted when it also lost precision.
      underCond   = issue.tiny & ~invalidCond & ~zeroCond
                    & (state_reg.en[EX_UNDER] | inexactCond);
      condVec                = 5'h00;
      condVec[EX_INVALID]    = invalidCond;
      condVec[EX_DIVZERO]    = zeroCond;
      condVec[EX_OVER]       = overCond;
      condVec[EX_UNDER]      = underCond;
      condVec[EX_INEXACT]    = inexactCond;
      causeNew               = {issue.unimpl, condVec};
   end

   // An enabled condition or an unimplemented operation traps; the rest are sticky only.
   assign trapNow = (|(condVec & state_reg.en)) | issue.unimpl;

   // Overflow default follows the rounding direction: infinity under round to nearest
   // or when the mode rounds away from zero for this sign, largest finite value otherwise.
   always_comb
   begin
      case (state_reg.rndSel)
         RND_NEAREST: toInfinity = 1'b1;
         RND_ZERO:    toInfinity = 1'b0;
         RND_UP:      toInfinity = ~issue.sign;
         RND_DOWN:    toInfinity = issue.sign;
         default:     toInfinity = 1'b1;
      endcase
   end

   // Choose which special pattern, if any, replaces the rounded value.
   always_comb
   begin
      useSpecial  = invalidCond | zeroCond | overCond;
      specialKind = SPC_MAX;
      if (invalidCond)
      begin
         specialKind = SPC_QNAN;
      end
      else if (zeroCond)
      begin
         specialKind = SPC_INF;
      end
      else if (overCond && toInfinity)
      begin
         specialKind = SPC_INF;
      end
      else
      begin
         specialKind = SPC_MAX;
      end
   end

   fpx_special_value u_special
   (
      .dbl   (issue.dbl),
      .sign  (issue.sign),
      .kind  (specialKind),
      .value (specialValue)
   );

   // Underflow and inexact keep the rounded value; see the field comments above.
   assign deliverValue = useSpecial ? specialValue : rounded;

   // Software writes first; same-cycle hardware events are merged on top so
   // that a flag raised in the clearing cycle survives.
   always_comb
   begin
      rndSelMerged = state_reg.rndSel;
      enMerged    = state_reg.en;
      causeMerged = state_reg.cause;
      flagsMerged = state_reg.flags;
      if (move.valid && move.write && regHit)
      begin
         rndSelMerged = move.data[RNDSEL_LSB +: 2];
         enMerged    = move.data[EN_LSB +: 5];
         causeMerged = move.data[CAUSE_LSB +: 6];
         flagsMerged = move.data[FLAG_LSB +: 5];
      end
      if (execute)
      begin
         // The cause field reflects only the latest executed instruction.
         causeMerged = causeNew;
         if (!trapNow)
         begin
            flagsMerged = flagsMerged | condVec;
         end
      end
   end

   // Next-state assembly for the whole block.
   always_comb
   begin
      state_next              = state_reg;
      state_next.rndSel       = rndSelMerged;
      state_next.en           = enMerged;
      state_next.cause        = causeMerged;
      state_next.flags        = flagsMerged;
      state_next.res.valid    = issue.valid;
      state_next.res.unusable = issue.valid & ~cuOn;
      state_next.res.trap     = execute & trapNow;
      // A trapping instruction leaves the destination untouched.
      state_next.res.write    = execute & ~trapNow;
      state_next.res.data     = execute ? deliverValue : 64'h0000_0000_0000_0000;
      state_next.rdAck        = move.valid;
      state_next.rdData       = state_reg.rdData;
      if (move.valid && !move.write)
      begin
         state_next.rdData = regHit ? csrWord : 32'h0000_0000;
      end
   end

   // Single state register; reset loads constants only.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg.rndSel       <= RNDSEL_RESET;
         state_reg.en           <= EN_RESET;
         state_reg.cause        <= CAUSE_RESET;
         state_reg.flags        <= FLAG_RESET;
         state_reg.res.valid    <= 1'b0;
         state_reg.res.write    <= 1'b0;
         state_reg.res.trap     <= 1'b0;
         state_reg.res.unusable <= 1'b0;
         state_reg.res.data     <= 64'h0000_0000_0000_0000;
         state_reg.rdAck        <= 1'b0;
         state_reg.rdData       <= 32'h0000_0000;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // All answers come straight from the state register.
   assign result    = state_reg.res;
   assign moveAck   = state_reg.rdAck;
   assign moveRdata = state_reg.rdData;

endmodule : fpx_control

// File: common/fpx_pkg.sv
// Package with the field layout, reset values and carrier types of the FP control block.
package fpx_pkg;

   // System coprocessor status word: coprocessor-one usable bit.
   localparam int unsigned CU_BIT       = 29;
   localparam logic [31:0] CU_MASK      = 32'h2000_0000;

   // Coprocessor register number of fp_control_status.
   localparam logic [4:0]  CSR_REGNUM   = 5'h1f;

   // Field positions inside fp_control_status.
   localparam int unsigned RNDSEL_LSB   = 0;
   localparam int unsigned FLAG_LSB     = 2;
   localparam int unsigned EN_LSB       = 7;
   localparam int unsigned CAUSE_LSB    = 12;
   localparam int unsigned NANENC_BIT   = 18;
   localparam int unsigned ABSSEM_BIT   = 19;

   // Read-only mode bits; fixed to the IEEE-2008 behaviour.
   localparam logic        NANENC_VALUE = 1'b1;
   localparam logic        ABSSEM_VALUE = 1'b1;

   // Values after reset.
   localparam logic [1:0]  RNDSEL_RESET = 2'h0;
   localparam logic [4:0]  EN_RESET     = 5'h00;
   localparam logic [5:0]  CAUSE_RESET  = 6'h00;
   localparam logic [4:0]  FLAG_RESET   = 5'h00;

   // Bit index of each condition inside the enable, flag and cause fields.
   localparam int unsigned EX_INEXACT   = 0;
   localparam int unsigned EX_UNDER     = 1;
   localparam int unsigned EX_OVER      = 2;
   localparam int unsigned EX_DIVZERO   = 3;
   localparam int unsigned EX_INVALID   = 4;
   localparam int unsigned EX_UNIMPL    = 5;

   // Rounding mode encodings.
   localparam logic [1:0]  RND_NEAREST  = 2'h0;
   localparam logic [1:0]  RND_ZERO     = 2'h1;
   localparam logic [1:0]  RND_UP       = 2'h2;
   localparam logic [1:0]  RND_DOWN     = 2'h3;

   // Special results, sign bit clear; single format sits in the low word.
   localparam logic [63:0] SGL_QNAN     = 64'h0000_0000_7fc0_0000;
   localparam logic [63:0] SGL_INF      = 64'h0000_0000_7f80_0000;
   localparam logic [63:0] SGL_MAX      = 64'h0000_0000_7f7f_ffff;
   localparam logic [63:0] DBL_QNAN     = 64'h7ff8_0000_0000_0000;
   localparam logic [63:0] DBL_INF      = 64'h7ff0_0000_0000_0000;
   localparam logic [63:0] DBL_MAX      = 64'h7fef_ffff_ffff_ffff;

   typedef enum logic [1:0] {SPC_QNAN, SPC_INF, SPC_MAX} fpx_special_t;

   // One instruction from the core with the datapath's condition report.
   typedef struct packed {
      logic        valid;
      logic        dbl;
      logic        sign;
      logic        invalid;
      logic        divZero;
      logic        overflow;
      logic        tiny;
      logic        unimpl;
      logic        guard;
      logic        sticky;
      logic [63:0] raw;
   } fpx_issue_t;

   // Coprocessor control register move from the core.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [4:0]  regNum;
      logic [31:0] data;
   } fpx_move_t;

   // Outcome of one instruction.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        trap;
      logic        unusable;
      logic [63:0] data;
   } fpx_result_t;

   // Whole state of the control block.
   typedef struct packed {
      logic [1:0]  rndSel;
      logic [4:0]  en;
      logic [5:0]  cause;
      logic [4:0]  flags;
      fpx_result_t res;
      logic        rdAck;
      logic [31:0] rdData;
   } fpx_state_t;

endpackage : fpx_pkg

// File: design/fpx_round_inc.sv
// Rounding increment decision for one result under the selected mode.
`timescale 1ns/1ps
module fpx_round_inc
(
   input  wire logic [1:0] rndSel,
   input  wire logic       sign,
   input  wire logic       lsb,
   input  wire logic       guard,
   input  wire logic       sticky,
   output logic            inc
);
   import fpx_pkg::*;

   // Decide whether the truncated magnitude must step up by one unit.
   always_comb
   begin
      case (rndSel)
         RND_NEAREST: inc = guard & (sticky | lsb);
         RND_ZERO:    inc = 1'b0;
         RND_UP:      inc = ~sign & (guard | sticky);
         RND_DOWN:    inc = sign & (guard | sticky);
         default:     inc = 1'b0;
      endcase
   end

endmodule : fpx_round_inc

// File: design/fpx_special_value.sv
// Builds the signed special results delivered under default handling.
`timescale 1ns/1ps
module fpx_special_value
(
   input  wire logic         dbl,
   input  wire logic         sign,
   input  wire fpx_pkg::fpx_special_t kind,
   output logic [63:0]       value
);
   import fpx_pkg::*;

   // Pick the pattern for the format, then place the sign in its top bit.
   always_comb
   begin
      case (kind)
         SPC_QNAN: value = dbl ? DBL_QNAN : SGL_QNAN;
         SPC_INF:  value = dbl ? DBL_INF : SGL_INF;
         SPC_MAX:  value = dbl ? DBL_MAX : SGL_MAX;
         default:  value = dbl ? DBL_QNAN : SGL_QNAN;
      endcase
      if (dbl)
      begin
         value[63] = sign;
      end
      else
      begin
         value[31] = sign;
      end
   end

endmodule : fpx_special_value

// File: tb/fpx_control_asserts.sv
// Concurrent checks on the ports of the FP control block.
`timescale 1ns/1ps
module fpx_control_asserts
   import fpx_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [31:0] sysStatus,
   input wire fpx_issue_t  issue,
   input wire fpx_move_t   move,
   input wire fpx_result_t result,
   input wire logic        moveAck,
   input wire logic [31:0] moveRdata,
   input wire logic        fpEnabled
);
   // One clock domain, so every check shares the clock and stands down in reset.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_enabled; fpEnabled == sysStatus[CU_BIT]; endproperty
   a_enabled: assert property (p_enabled) else $error("enable differs from usable bit");
   property p_unusable;
      issue.valid && !sysStatus[CU_BIT] |=> result.valid && result.unusable && !result.write;
   endproperty
   a_unusable: assert property (p_unusable) else $error("issue not refused");
   property p_ack; move.valid |=> moveAck; endproperty
   a_ack: assert property (p_ack) else $error("move not acknowledged");
   property p_rdbits; move.valid && !move.write && move.regNum == 5'h1f |=> moveRdata[31:18] == 14'h3;
   endproperty
   a_rdbits: assert property (p_rdbits) else $error("fixed bits wrong");
   property p_rdhold; !(move.valid && !move.write) |=> $stable(moveRdata); endproperty
   a_rdhold: assert property (p_rdhold) else $error("read data moved");
   property p_qnan; issue.valid && fpEnabled && issue.invalid && !issue.dbl
      |=> result.data[31:0] == {$past(issue.sign), SGL_QNAN[30:0]}; endproperty
   a_qnan: assert property (p_qnan) else $error("default NaN wrong");
   property p_inf; issue.valid && fpEnabled && issue.divZero && !issue.invalid && issue.dbl
      |=> result.data == {$past(issue.sign), DBL_INF[62:0]}; endproperty
   a_inf: assert property (p_inf) else $error("default infinity wrong");
   property p_unimpl; issue.valid && fpEnabled && issue.unimpl |=> result.trap && !result.write;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented did not trap");
   c_trap: cover property (result.valid && result.trap);
   c_unusable: cover property (result.valid && result.unusable);
   c_read: cover property (move.valid && !move.write ##1 moveAck);
endmodule : fpx_control_asserts

// File: tb/fpx_core_model.sv
// Integer core model: presents one instruction or move per cycle.
`timescale 1ns/1ps
module fpx_core_model
(
   input wire logic          mclk,
   output fpx_pkg::fpx_issue_t issue,
   output fpx_pkg::fpx_move_t  move,
   output logic [31:0]       sysStatus
);
   import fpx_pkg::*;
   initial
   begin
      issue = '0;
      move = '0;
      sysStatus = '0;
   end
   // Idle fields flip each cycle so the block cannot lean on stale values.
   task automatic step(input fpx_issue_t i, input fpx_move_t m, input logic [31:0] s);
      @(posedge mclk);
      #1;
      issue = i.valid ? i : ~issue;
      issue.valid = i.valid;
      move = m.valid ? m : ~move;
      move.valid = m.valid;
      sysStatus = s;
   endtask : step
endmodule : fpx_core_model

// File: tb/fp_exception_round_control_tb.sv
// Self-checking bench for the FP control block with a result scoreboard.
`timescale 1ns/1ps
`define CHK(got, want) begin nChecks++; if ((got) !== (want)) begin nFail++; \
   $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module fp_exception_round_control_tb;
   import fpx_pkg::*;
   logic        mclk;
   logic        rst_n;
   logic [31:0] sysStatus;
   fpx_issue_t  issue;
   fpx_move_t   move;
   fpx_result_t result;
   logic        moveAck;
   logic [31:0] moveRdata;
   logic        fpEnabled;
   int          nFail, nChecks, seed, r, k;
   logic        usable;
   logic [1:0]  rndSel;
   logic [4:0]  en, flags;
   logic [5:0]  cause;
   logic [66:0] expRes[$], e;
   logic [32:0] expAck[$], a;
   fpx_issue_t  x;

   fpx_control dut_u (.mclk(mclk), .rst_n(rst_n), .sysStatus(sysStatus), .issue(issue),
      .move(move), .result(result), .moveAck(moveAck), .moveRdata(moveRdata),
      .fpEnabled(fpEnabled));
   fpx_core_model core_u (.mclk(mclk), .issue(issue), .move(move), .sysStatus(sysStatus));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Reference outcome of one executed instruction; updates the shadow cause and flags.
   function automatic logic [66:0] expect_op(input fpx_issue_t i);
      logic        v, z, o, ix, u, tr, inc, up;
      logic [63:0] d, sb;
      v = i.invalid;
      z = i.divZero & ~v;
      o = i.overflow & ~v & ~z;
      ix = (i.guard | i.sticky | o) & ~v & ~z;
      u = i.tiny & ~v & ~z & (en[EX_UNDER] | ix);
      cause = {i.unimpl, v, z, o, u, ix};
      tr = (|(cause[4:0] & en)) | i.unimpl;
      up = rndSel == RND_NEAREST || (rndSel == RND_UP && !i.sign)
           || (rndSel == RND_DOWN && i.sign);
      case (rndSel)
         RND_NEAREST: inc = i.guard & (i.sticky | i.raw[0]);
         RND_ZERO:    inc = 1'b0;
         RND_UP:      inc = ~i.sign & (i.guard | i.sticky);
         default:     inc = i.sign & (i.guard | i.sticky);
      endcase
      sb = i.dbl ? {i.sign, 63'h0} : {32'h0, i.sign, 31'h0};
      if (v) d = (i.dbl ? DBL_QNAN : SGL_QNAN) | sb;
      else if (z || (o && up)) d = (i.dbl ? DBL_INF : SGL_INF) | sb;
      else if (o) d = (i.dbl ? DBL_MAX : SGL_MAX) | sb;
      else d = i.raw + 64'(inc);
      if (!tr) flags = flags | cause[4:0];
      return {~tr, tr, 1'b0, d};
   endfunction : expect_op

   // The status word carries noise apart from the usable bit.
   task automatic step(input fpx_issue_t i, input fpx_move_t m);
      logic [31:0] s;
      s = $random(seed);
      s[CU_BIT] = usable;
      core_u.step(i, m, s);
   endtask : step

   task automatic wr(input logic [4:0] n, input logic [31:0] d);
      if (n == CSR_REGNUM) {cause, en, flags, rndSel} = d[17:0];
      expAck.push_back(33'h0);
      step('0, {1'b1, 1'b1, n, d});
   endtask : wr

   task automatic rd(input logic [4:0] n);
      expAck.push_back({1'b1, n == CSR_REGNUM ? {14'h3, cause, en, flags, rndSel} : 32'h0});
      step('0, {1'b1, 1'b0, n, 32'h0});
   endtask : rd

   // Random instruction with rare conditions; raw keeps clear of a carry out.
   task automatic op;
      r = $random(seed);
      x = '0;
      x.valid = 1'b1;
      x.dbl = r[0];
      x.sign = r[1];
      x.invalid = r[4:2] == 3'h0;
      x.divZero = r[7:5] == 3'h0;
      x.overflow = r[10:8] == 3'h0;
      x.tiny = r[12:11] == 2'h0;
      x.unimpl = r[16:13] == 4'h0;
      x.guard = r[17];
      x.sticky = r[18];
      x.raw = {$random(seed), $random(seed)};
      if (!x.dbl) x.raw[63:32] = '0;
      x.raw[x.dbl ? 62 : 30] = 1'b0;
      expRes.push_back(usable ? expect_op(x) : {3'h1, 64'h0});
      step(x, '0);
   endtask : op

   task automatic testDone;
      $display("checks %0d mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : testDone

   // Scoreboard: every answer takes the oldest note of its kind; none left reads as unknown.
   always @(posedge mclk)
   begin
      #2;
      if (result.valid)
      begin
         e = expRes.size() ? expRes.pop_front() : 'x;
         `CHK({result.write, result.trap, result.unusable, result.data}, e)
      end
      if (moveAck)
      begin
         a = expAck.size() ? expAck.pop_front() : {1'b1, 32'hx};
         if (a[32]) `CHK(moveRdata, a[31:0])
      end
   end

   initial
   begin
      #300000;
      nFail++;
      $display("unexpected at %0t: run too long", $time);
      testDone();
   end

   // Main sequence: reset image, ignored writes, every rounding mode, then refusals.
   initial
   begin
      seed = 35165;
      nFail = 0;
      nChecks = 0;
      usable = 1'b1;
      {cause, en, flags, rndSel} = '0;
      rst_n = 1'b0;
      repeat (12) @(posedge mclk);
      #1 rst_n = 1'b1;
      rd(CSR_REGNUM);
      rd(5'h1a);
      wr(5'h03, 32'hffff_ffff);
      rd(CSR_REGNUM);
      wr(CSR_REGNUM, 32'hffff_ffff);
      rd(CSR_REGNUM);
      for (k = 0; k < 8; k++)
      begin
         r = $random(seed);
         wr(CSR_REGNUM, (32'(r) & (k < 4 ? 32'hffff_fffc : 32'hffff_f07c)) | 32'(k % 4));
         repeat (40) op();
         rd(CSR_REGNUM);
      end
      // A reset in mid-run must bring back the reset image; idle first so no answer is lost.
      repeat (2) step('0, '0);
      rst_n = 1'b0;
      {cause, en, flags, rndSel} = '0;
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'b1;
      rd(CSR_REGNUM);
      usable = 1'b0;
      repeat (3) op();
      usable = 1'b1;
      op();
      rd(CSR_REGNUM);
      step('0, '0);
      for (k = 0; k < 20 && (expRes.size() || expAck.size()); k++) @(posedge mclk);
      if (expRes.size() || expAck.size())
      begin
         nFail++;
         $display("unexpected at %0t: answers missing", $time);
      end
      testDone();
   end
endmodule : fp_exception_round_control_tb

bind fpx_control fpx_control_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .sysStatus(sysStatus),
   .issue(issue), .move(move), .result(result), .moveAck(moveAck), .moveRdata(moveRdata),
   .fpEnabled(fpEnabled));
